// ===== shared/cies_params.svh
`ifndef CIES_PARAMS_SVH
`define CIES_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CIES_PC_W 15
`define CIES_LATCH_W 7
`define CIES_FADDR_W 7
`define CIES_BSEL_W 3
`define CIES_LIT_W 11
`define CIES_DATA_W 8
`define CIES_WDT_CNT_W 8
`define CIES_WDT_PRE_W 8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CIES_OFF_ACC 12'h000
`define CIES_OFF_LATCH 12'h004
`define CIES_OFF_STATUS 12'h008
`define CIES_OFF_PC 12'h00c
`define CIES_OFF_STACK 12'h010
`define CIES_OFF_WDT 12'h014
`define CIES_OFF_FILE_BASE 12'h200
`define CIES_FILE_SEL_HI 11
`define CIES_FILE_SEL_LO 9
`define CIES_FILE_SEL_VAL 3'h1

// ----------------------------------------
// Status and watchdog field positions
// ----------------------------------------
`define CIES_ST_ZERO 2
`define CIES_ST_SLEEP_N 3
`define CIES_ST_EXPIRY_N 4
`define CIES_WDT_PRE_LSB 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIES_RST_PC 15'h0000
`define CIES_RST_ACC 8'h00
`define CIES_RST_LATCH 7'h00

`endif

// ===== shared/cies_pkg.sv
package cies_pkg;

	// Decoded opcodes presented by the fetch stage
	typedef enum logic [3:0] {
		CIES_OP_NOP = 4'h0,
		CIES_OP_SKIP_IF_BIT_HIGH = 4'h1,
		CIES_OP_SKIP_IF_BIT_LOW = 4'h2,
		CIES_OP_SUBROUTINE_JUMP = 4'h3,
		CIES_OP_SUBROUTINE_JUMP_COMPUTED = 4'h4,
		CIES_OP_ZERO_FILE = 4'h5,
		CIES_OP_ZERO_ACCUMULATOR = 4'h6,
		CIES_OP_WATCHDOG_KICK = 4'h7,
		CIES_OP_INVERT_FILE = 4'h8,
		CIES_OP_DECREMENT_FILE = 4'h9
	} cies_op_t;

	// Execution sequencer
	typedef enum logic [1:0] {
		CIES_ST_EXEC = 2'b01,
		CIES_ST_SECOND = 2'b10
	} cies_state_t;

endpackage

// ===== verif/cies_exec_monitor.sv
`timescale 1ns/1ps
module cies_exec_chk (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Instruction side
	input wire logic instr_valid_in,
	input wire cies_pkg::cies_op_t op_in,
	input wire logic dest_in,
	input wire logic [10:0] literal_in,
	input wire logic sleep_enter_in,
	input wire logic instr_ready_out,
	input wire logic [14:0] pc_out,
	input wire logic [7:0] acc_out,
	input wire logic [14:0] stack_top_entry_out,
	input wire logic stack_push_out,
	input wire logic zero_flag_out,
	input wire logic expiry_flag_n_out,
	input wire logic sleep_flag_n_out,
	// Bus side
	input wire logic psel,
	input wire logic penable,
	input wire logic pready
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic tk;
	assign tk = instr_valid_in && instr_ready_out;
	sequence two_cyc;
		!instr_ready_out ##1 instr_ready_out;
	endsequence
	sequence pushed;
		stack_push_out && stack_top_entry_out == $past(pc_out) + 15'h0001;
	endsequence
	AST_SKIP: assert property (tk && op_in inside {cies_pkg::CIES_OP_SKIP_IF_BIT_HIGH,
		cies_pkg::CIES_OP_SKIP_IF_BIT_LOW} |=> (instr_ready_out && pc_out == $past(pc_out) + 15'h0001)
		or (!instr_ready_out ##1 (instr_ready_out && pc_out == $past(pc_out, 2) + 15'h0002)))
		else $error("skip timing wrong");
	AST_CALL: assert property (tk && op_in == cies_pkg::CIES_OP_SUBROUTINE_JUMP
		|=> pushed ##0 pc_out[10:0] == $past(literal_in) ##0 two_cyc) else $error("call wrong");
	AST_SUBROUTINE_JUMP_COMPUTED: assert property (tk && op_in == cies_pkg::CIES_OP_SUBROUTINE_JUMP_COMPUTED
		|=> pushed ##0 pc_out[7:0] == $past(acc_out) ##0 two_cyc) else $error("computed call wrong");
	// The zero flag must ride through both cycles of a call
	AST_CALL_FLAGS: assert property (tk && op_in inside {cies_pkg::CIES_OP_SUBROUTINE_JUMP,
		cies_pkg::CIES_OP_SUBROUTINE_JUMP_COMPUTED} |=> $stable(zero_flag_out) [*2])
		else $error("call touched zero flag");
	AST_ZFILE: assert property (tk && op_in == cies_pkg::CIES_OP_ZERO_FILE
		|=> zero_flag_out && instr_ready_out) else $error("zero file flag wrong");
	AST_ZACC: assert property (tk && op_in == cies_pkg::CIES_OP_ZERO_ACCUMULATOR
		|=> acc_out == 8'h00 && zero_flag_out) else $error("zero acc wrong");
	// Sleep entry wins over a kick, so leave that cycle out
	AST_KICK: assert property (tk && op_in == cies_pkg::CIES_OP_WATCHDOG_KICK && !sleep_enter_in
		|=> sleep_flag_n_out && expiry_flag_n_out) else $error("kick flags wrong");
	AST_INV: assert property (tk && op_in == cies_pkg::CIES_OP_INVERT_FILE && !dest_in
		|=> zero_flag_out == (acc_out == 8'h00)) else $error("invert flag wrong");
	AST_DEC: assert property (tk && op_in == cies_pkg::CIES_OP_DECREMENT_FILE
		|=> instr_ready_out && ($past(dest_in) || zero_flag_out == (acc_out == 8'h00)))
		else $error("decrement wrong");
	AST_PREADY: assert property (psel && !penable |=> pready) else $error("no ready");
endmodule

bind cies_exec cies_exec_chk i_chk (.clock_in, .rstn_in, .instr_valid_in, .op_in, .dest_in, .literal_in,
	.sleep_enter_in, .instr_ready_out, .pc_out, .acc_out, .stack_top_entry_out, .stack_push_out,
	.zero_flag_out, .expiry_flag_n_out, .sleep_flag_n_out, .psel, .penable, .pready);

// ===== verif/cies_exec_test.sv
`timescale 1ns/1ps
module cies_exec_test;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic instr_valid_in = 1'b0;
	cies_pkg::cies_op_t op_in = cies_pkg::CIES_OP_NOP;
	logic [6:0] file_addr_in = 7'h0;
	logic [2:0] bit_sel_in = 3'h0;
	logic dest_in = 1'b0;
	logic [10:0] literal_in = 11'h0;
	logic sleep_enter_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic instr_ready_out, stack_push_out, zero_flag_out, expiry_flag_n_out, sleep_flag_n_out;
	logic [14:0] pc_out, stack_top_entry_out;
	logic [7:0] acc_out;
	logic [31:0] prdata, r;
	logic pready, pslverr, e;
	int failures = 0;
	int compares = 0;

	cies_exec i_dut (.clock_in, .rstn_in, .instr_valid_in, .op_in, .file_addr_in, .bit_sel_in, .dest_in,
		.literal_in, .instr_ready_out, .sleep_enter_in, .pc_out, .acc_out, .stack_top_entry_out,
		.stack_push_out, .zero_flag_out, .expiry_flag_n_out, .sleep_flag_n_out, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

	always #12.5 clock_in = ~clock_in;

	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Starts just after a rising edge; pready, prdata and pslverr are taken at the completing edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do begin
			@(posedge clock_in);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never reassigns psel in this time step
		@(posedge clock_in);
	endtask

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, r, exp);
	endtask

	task automatic ex(input cies_pkg::cies_op_t o, input logic [6:0] f, input logic [2:0] b, input logic d,
		input logic [10:0] k);
		instr_valid_in <= 1'b1;
		op_in <= o;
		file_addr_in <= f;
		bit_sel_in <= b;
		dest_in <= d;
		literal_in <= k;
		do begin
			@(posedge clock_in);
		end while (instr_ready_out !== 1'b1);
		instr_valid_in <= 1'b0;
		// Two more edges let a two-cycle op finish before outputs are read
		repeat (2) @(posedge clock_in);
	endtask

	task automatic stop_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----
	// Tests
	// ----
	initial begin
		repeat (3) @(posedge clock_in);
		rstn_in <= 1'b1;
		rd("status", 12'h008, 32'h18);
		apb(1'b1, 12'h004, 32'h7f);
		apb(1'b1, 12'h000, 32'h5a);
		apb(1'b1, 12'h20c, 32'h80);
		apb(1'b1, 12'h210, 32'h0f);
		apb(1'b1, 12'h214, 32'h01);
		rd("hole", 12'h100, 32'h0);
		chk("slverr", 32'(e), 32'h1);
		$display("test registers done");
		ex(cies_pkg::CIES_OP_SKIP_IF_BIT_HIGH, 7'h3, 3'h7, 1'b0, 11'h0);
		chk("pc", 32'(pc_out), 32'h2);
		ex(cies_pkg::CIES_OP_SKIP_IF_BIT_HIGH, 7'h3, 3'h6, 1'b0, 11'h0);
		chk("pc", 32'(pc_out), 32'h3);
		ex(cies_pkg::CIES_OP_SKIP_IF_BIT_LOW, 7'h3, 3'h7, 1'b0, 11'h0);
		chk("pc", 32'(pc_out), 32'h4);
		ex(cies_pkg::CIES_OP_SKIP_IF_BIT_LOW, 7'h3, 3'h0, 1'b0, 11'h0);
		chk("pc", 32'(pc_out), 32'h6);
		$display("test skips done");
		ex(cies_pkg::CIES_OP_SUBROUTINE_JUMP, 7'h0, 3'h0, 1'b0, 11'h123);
		chk("pc", 32'(pc_out), 32'h7923);
		chk("stack", 32'(stack_top_entry_out), 32'h7);
		ex(cies_pkg::CIES_OP_SUBROUTINE_JUMP_COMPUTED, 7'h0, 3'h0, 1'b0, 11'h0);
		chk("pc", 32'(pc_out), 32'h7f5a);
		chk("stack", 32'(stack_top_entry_out), 32'h7924);
		$display("test calls done");
		ex(cies_pkg::CIES_OP_INVERT_FILE, 7'h4, 3'h0, 1'b0, 11'h0);
		chk("acc", 32'(acc_out), 32'hf0);
		rd("file4", 12'h210, 32'h0f);
		ex(cies_pkg::CIES_OP_INVERT_FILE, 7'h4, 3'h0, 1'b1, 11'h0);
		rd("file4", 12'h210, 32'hf0);
		ex(cies_pkg::CIES_OP_ZERO_ACCUMULATOR, 7'h0, 3'h0, 1'b0, 11'h0);
		chk("acc", 32'(acc_out), 32'h0);
		ex(cies_pkg::CIES_OP_DECREMENT_FILE, 7'h3, 3'h0, 1'b1, 11'h0);
		rd("file3", 12'h20c, 32'h7f);
		ex(cies_pkg::CIES_OP_ZERO_FILE, 7'h3, 3'h0, 1'b0, 11'h0);
		rd("file3", 12'h20c, 32'h0);
		ex(cies_pkg::CIES_OP_DECREMENT_FILE, 7'h3, 3'h0, 1'b1, 11'h0);
		rd("file3", 12'h20c, 32'hff);
		chk("zero", 32'(zero_flag_out), 32'h0);
		ex(cies_pkg::CIES_OP_DECREMENT_FILE, 7'h5, 3'h0, 1'b0, 11'h0);
		chk("zero", 32'(zero_flag_out), 32'h1);
		$display("test data ops done");
		@(posedge clock_in);
		sleep_enter_in <= 1'b1;
		@(posedge clock_in);
		sleep_enter_in <= 1'b0;
		// Long enough for the watchdog counter to have moved
		repeat (300) @(posedge clock_in);
		rd("status", 12'h008, 32'h14);
		apb(1'b0, 12'h014, 32'h0);
		chk("wdt moved", 32'(r[7:0] != 8'h00), 32'h1);
		ex(cies_pkg::CIES_OP_WATCHDOG_KICK, 7'h0, 3'h0, 1'b0, 11'h0);
		chk("sleep", 32'(sleep_flag_n_out), 32'h1);
		apb(1'b0, 12'h014, 32'h0);
		chk("wdt count", 32'(r[7:0]), 32'h0);
		chk("wdt pre", 32'(r[15:8] < 8'h08), 32'h1);
		$display("test watchdog done");
		stop_test();
	end

	// Tests take under a thousand cycles
	initial begin
		#100000;
		failures++;
		stop_test();
	end
endmodule

// ===== verilog/cies_exec.sv
// Notes on behaviour
// - Skip-high: bit set discards next, two cycles
// - Call pushes return address on the same edge that PC changes
// - Call: literal to PC[10:0], latch[6:3] above
// - Call takes two cycles, flags untouched
// - Computed call: push, acc low, latch high
// - Computed call takes two cycles, flags untouched
// - Zero-file clears register, sets zero flag
// - Zero-accumulator clears acc, sets zero flag only
// - Watchdog kick clears counter and prescaler
// - Watchdog kick sets expiry and sleep flags; same-cycle expiry or sleep entry wins
// - Invert-file complements, zero flag from result
// - Destination bit picks accumulator or file
// - Decrement-file wraps mod 256, zero flag, no skip
// - Skip-low: bit clear discards next, two cycles
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "cies_params.svh"

module cies_exec #(
	parameter int WDT_CNT_W = `CIES_WDT_CNT_W,
	parameter int WDT_PRE_W = `CIES_WDT_PRE_W
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rstn_in,
	// Decoded instruction
	input wire logic instr_valid_in,
	input wire cies_pkg::cies_op_t op_in,
	input wire logic [`CIES_FADDR_W-1:0] file_addr_in,
	input wire logic [`CIES_BSEL_W-1:0] bit_sel_in,
	input wire logic dest_in,
	input wire logic [`CIES_LIT_W-1:0] literal_in,
	output logic instr_ready_out,
	// Core state
	input wire logic sleep_enter_in,
	output logic [`CIES_PC_W-1:0] pc_out,
	output logic [`CIES_DATA_W-1:0] acc_out,
	output logic [`CIES_PC_W-1:0] stack_top_entry_out,
	output logic stack_push_out,
	output logic zero_flag_out,
	output logic expiry_flag_n_out,
	output logic sleep_flag_n_out,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	cies_pkg::cies_state_t state, next_state;
	logic [`CIES_PC_W-1:0] pc, next_pc;
	logic [`CIES_DATA_W-1:0] acc, next_acc;
	logic [`CIES_LATCH_W-1:0] latch, next_latch;
	logic [`CIES_PC_W-1:0] stack_top, next_stack_top;
	logic push, next_push;
	logic zero, next_zero;
	logic expiry_n, next_expiry_n;
	logic sleep_n, next_sleep_n;
	logic ready, next_ready;
	logic [WDT_PRE_W-1:0] wdt_pre, next_wdt_pre;
	logic [WDT_CNT_W-1:0] wdt_cnt, next_wdt_cnt;
	logic [31:0] rdata, next_rdata;
	logic rdy, next_rdy;
	logic err, next_err;

	// File bank access
	logic file_we;
	logic [`CIES_FADDR_W-1:0] file_waddr;
	logic [`CIES_DATA_W-1:0] file_wdata;
	logic [`CIES_DATA_W-1:0] file_q;
	logic [`CIES_DATA_W-1:0] apb_file_q;

	// Instruction decode helpers
	logic take;
	logic tested_bit;
	logic [`CIES_DATA_W-1:0] result;
	logic writes_result;
	logic instr_file_we;
	logic acc_by_instr;
	logic wdt_expire;

	// APB decode helpers
	logic apb_setup;
	logic apb_write_done;
	logic file_hit;
	logic reg_hit;
	logic [`CIES_FADDR_W-1:0] apb_file_addr;

	cies_file_bank #(
		.DEPTH(128)
	) u_bank (
		.clock_in(clock_in),
		.wr_en_in(file_we),
		.wr_addr_in(file_waddr),
		.wr_data_in(file_wdata),
		.rd_a_addr_in(file_addr_in),
		.rd_a_data_out(file_q),
		.rd_b_addr_in(apb_file_addr),
		.rd_b_data_out(apb_file_q)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign take = instr_valid_in && ready;
	assign tested_bit = file_q[bit_sel_in];
	assign apb_file_addr = paddr[8:2];
	assign file_hit = paddr[`CIES_FILE_SEL_HI:`CIES_FILE_SEL_LO] == `CIES_FILE_SEL_VAL;
	assign apb_setup = psel && !penable;
	assign apb_write_done = psel && penable && pready && pwrite;

	always_comb begin
		result = 8'h00;
		writes_result = 1'b0;
		case (op_in)
			cies_pkg::CIES_OP_ZERO_FILE: begin
				result = 8'h00;
				writes_result = 1'b1;
			end
			cies_pkg::CIES_OP_INVERT_FILE: begin
				result = ~file_q;
				writes_result = 1'b1;
			end
			cies_pkg::CIES_OP_DECREMENT_FILE: begin
				result = file_q - 8'h01;
				writes_result = 1'b1;
			end
			default: begin
				result = 8'h00;
				writes_result = 1'b0;
			end
		endcase
	end

	// Zero-file always lands in the file; the others follow the destination bit
	assign instr_file_we = take && writes_result &&
		(dest_in || op_in == cies_pkg::CIES_OP_ZERO_FILE);
	assign acc_by_instr = take && (op_in == cies_pkg::CIES_OP_ZERO_ACCUMULATOR ||
		(writes_result && !dest_in && op_in != cies_pkg::CIES_OP_ZERO_FILE));

	// Instruction write beats a bus write landing in the same cycle
	always_comb begin
		file_we = 1'b0;
		file_waddr = file_addr_in;
		file_wdata = result;
		if (instr_file_we) begin
			file_we = 1'b1;
		end else if (apb_write_done && file_hit) begin
			file_we = 1'b1;
			file_waddr = apb_file_addr;
			file_wdata = pwdata[`CIES_DATA_W-1:0];
		end
	end

	// ----------------------------------------
	// Sequencer and core registers
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_acc = acc;
		next_latch = latch;
		next_stack_top = stack_top;
		next_push = 1'b0;
		next_zero = zero;
		case (state)
			cies_pkg::CIES_ST_EXEC: begin
				if (take) begin
					next_pc = pc + 15'h0001;
					case (op_in)
						cies_pkg::CIES_OP_SKIP_IF_BIT_HIGH: begin
							if (tested_bit) begin
								next_state = cies_pkg::CIES_ST_SECOND;
							end
						end
						cies_pkg::CIES_OP_SKIP_IF_BIT_LOW: begin
							if (!tested_bit) begin
								next_state = cies_pkg::CIES_ST_SECOND;
							end
						end
						cies_pkg::CIES_OP_SUBROUTINE_JUMP: begin
							next_stack_top = pc + 15'h0001;
							next_push = 1'b1;
							next_pc = {latch[6:3], literal_in};
							next_state = cies_pkg::CIES_ST_SECOND;
						end
						cies_pkg::CIES_OP_SUBROUTINE_JUMP_COMPUTED: begin
							next_stack_top = pc + 15'h0001;
							next_push = 1'b1;
							next_pc = {latch, acc};
							next_state = cies_pkg::CIES_ST_SECOND;
						end
						cies_pkg::CIES_OP_ZERO_FILE: begin
							next_zero = 1'b1;
						end
						cies_pkg::CIES_OP_ZERO_ACCUMULATOR: begin
							next_acc = 8'h00;
							next_zero = 1'b1;
						end
						cies_pkg::CIES_OP_INVERT_FILE, cies_pkg::CIES_OP_DECREMENT_FILE: begin
							next_zero = result == 8'h00;
							if (!dest_in) begin
								next_acc = result;
							end
						end
						default: begin
							next_state = cies_pkg::CIES_ST_EXEC;
						end
					endcase
				end
			end
			cies_pkg::CIES_ST_SECOND: begin
				// Forced no-op slot; a skip steps over the discarded word
				if (!push) begin
					next_pc = pc + 15'h0001;
				end
				next_state = cies_pkg::CIES_ST_EXEC;
			end
			default: begin
				next_state = cies_pkg::CIES_ST_EXEC;
			end
		endcase
		// Software writes lose to an instruction touching the same register
		if (apb_write_done && !file_hit) begin
			if (paddr == `CIES_OFF_ACC && !acc_by_instr) begin
				next_acc = pwdata[`CIES_DATA_W-1:0];
			end
			if (paddr == `CIES_OFF_LATCH) begin
				next_latch = pwdata[`CIES_LATCH_W-1:0];
			end
		end
		next_ready = next_state == cies_pkg::CIES_ST_EXEC;
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			state <= cies_pkg::CIES_ST_EXEC;
			pc <= `CIES_RST_PC;
			acc <= `CIES_RST_ACC;
			latch <= `CIES_RST_LATCH;
			stack_top <= `CIES_RST_PC;
			push <= 1'b0;
			zero <= 1'b0;
			ready <= 1'b1;
		end else begin
			state <= next_state;
			pc <= next_pc;
			acc <= next_acc;
			latch <= next_latch;
			stack_top <= next_stack_top;
			push <= next_push;
			zero <= next_zero;
			ready <= next_ready;
		end
	end

	// ----------------------------------------
	// Watchdog and power flags
	// ----------------------------------------
	assign wdt_expire = (&wdt_pre) && (&wdt_cnt);

	always_comb begin
		next_wdt_pre = wdt_pre + 1'b1;
		next_wdt_cnt = (&wdt_pre) ? wdt_cnt + 1'b1 : wdt_cnt;
		next_expiry_n = expiry_n;
		next_sleep_n = sleep_n;
		if (take && op_in == cies_pkg::CIES_OP_WATCHDOG_KICK) begin
			next_wdt_pre = '0;
			next_wdt_cnt = '0;
			next_expiry_n = 1'b1;
			next_sleep_n = 1'b1;
		end
		// Hardware events win over the kick in the same cycle
		if (wdt_expire) begin
			next_expiry_n = 1'b0;
		end
		if (sleep_enter_in) begin
			next_sleep_n = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			wdt_pre <= '0;
			wdt_cnt <= '0;
			expiry_n <= 1'b1;
			sleep_n <= 1'b1;
		end else begin
			wdt_pre <= next_wdt_pre;
			wdt_cnt <= next_wdt_cnt;
			expiry_n <= next_expiry_n;
			sleep_n <= next_sleep_n;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Read data is captured in the setup cycle so it leaves a flop
	always_comb begin
		next_rdata = 32'h0000_0000;
		reg_hit = 1'b1;
		if (file_hit) begin
			next_rdata[`CIES_DATA_W-1:0] = apb_file_q;
		end else begin
			case (paddr)
				`CIES_OFF_ACC: next_rdata[`CIES_DATA_W-1:0] = acc;
				`CIES_OFF_LATCH: next_rdata[`CIES_LATCH_W-1:0] = latch;
				`CIES_OFF_STATUS: begin
					next_rdata[`CIES_ST_ZERO] = zero;
					next_rdata[`CIES_ST_SLEEP_N] = sleep_n;
					next_rdata[`CIES_ST_EXPIRY_N] = expiry_n;
				end
				`CIES_OFF_PC: next_rdata[`CIES_PC_W-1:0] = pc;
				`CIES_OFF_STACK: next_rdata[`CIES_PC_W-1:0] = stack_top;
				`CIES_OFF_WDT: begin
					next_rdata[WDT_CNT_W-1:0] = wdt_cnt;
					next_rdata[`CIES_WDT_PRE_LSB +: WDT_PRE_W] = wdt_pre;
				end
				default: reg_hit = 1'b0;
			endcase
		end
		if (!(apb_setup && !pwrite)) begin
			next_rdata = 32'h0000_0000;
		end
		next_rdy = apb_setup;
		next_err = apb_setup && !reg_hit;
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			rdata <= 32'h0000_0000;
			rdy <= 1'b0;
			err <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rdy <= next_rdy;
			err <= next_err;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign instr_ready_out = ready;
	assign pc_out = pc;
	assign acc_out = acc;
	assign stack_top_entry_out = stack_top;
	assign stack_push_out = push;
	assign zero_flag_out = zero;
	assign expiry_flag_n_out = expiry_n;
	assign sleep_flag_n_out = sleep_n;
	assign prdata = rdata;
	assign pready = rdy;
	assign pslverr = err;

endmodule

// ===== verilog/cies_file_bank.sv
`timescale 1ns/1ps
`include "cies_params.svh"

module cies_file_bank #(
	parameter int DEPTH = 128
) (
	// Clock
	input wire logic clock_in,
	// Write port
	input wire logic wr_en_in,
	input wire logic [`CIES_FADDR_W-1:0] wr_addr_in,
	input wire logic [`CIES_DATA_W-1:0] wr_data_in,
	// Read ports
	input wire logic [`CIES_FADDR_W-1:0] rd_a_addr_in,
	output logic [`CIES_DATA_W-1:0] rd_a_data_out,
	input wire logic [`CIES_FADDR_W-1:0] rd_b_addr_in,
	output logic [`CIES_DATA_W-1:0] rd_b_data_out
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Contents are not cleared by reset, as in a real data bank
	logic [`CIES_DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	assign rd_a_data_out = mem[rd_a_addr_in];
	assign rd_b_data_out = mem[rd_b_addr_in];

endmodule
